// ===== bench/pse_engine_model.sv
// detect and classify engine model answering the port requests
`timescale 1ns/100ps
`default_nettype none
module pse_engine_model
#(
  parameter int RUN_CYCLES = 8
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // requests from the control block
  input wire logic [3:0] i_detect_req,
  input wire logic [3:0] i_classify_req,
  // results back to the control block
  output logic [3:0] o_detect_done,
  output logic [3:0] o_classify_done,
  output logic [3:0] o_class_ok
);
  for (genvar p = 0; p < 4; p++)
  begin : g_port
    logic [3:0] det_cnt;
    logic [3:0] cls_cnt;
    // each run lasts a fixed time, then one done pulse
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        det_cnt <= 4'h0;
        cls_cnt <= 4'h0;
      end
      else
      begin
        if (det_cnt != 4'h0)
          det_cnt <= (det_cnt == 4'(RUN_CYCLES)) ? 4'h0 : det_cnt + 4'h1;
        else
          det_cnt <= {3'h0, i_detect_req[p]};
        if (cls_cnt != 4'h0)
          cls_cnt <= (cls_cnt == 4'(RUN_CYCLES)) ? 4'h0 : cls_cnt + 4'h1;
        else
          cls_cnt <= {3'h0, i_classify_req[p]};
      end
    end
    assign o_detect_done[p] = (det_cnt == 4'(RUN_CYCLES));
    assign o_classify_done[p] = (cls_cnt == 4'(RUN_CYCLES));
    assign o_class_ok[p] = (cls_cnt == 4'(RUN_CYCLES));
  end
endmodule
`default_nettype wire

// ===== bench/test_pse_port_mode_control.sv
// self-checking bench of the port mode control register block
`timescale 1ns/100ps
`default_nettype none
module test_pse_port_mode_control;
  localparam int TICK = 10;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  pse_ctl_pkg::byte_t cmd_code = 8'h00;
  pse_ctl_pkg::byte_t cmd_data = 8'h00;
  pse_ctl_pkg::byte_t rd_data;
  logic rd_valid;
  logic auto_pin = 1'b1;
  logic [3:0] imp_high = 4'h0;
  logic [3:0] cur_low = 4'h0;
  logic [3:0] cur_over = 4'h0;
  logic [3:0] foldback = 4'h0;
  logic osc_invalid = 1'b0;
  logic irq_pending = 1'b0;
  logic [3:0] det_done, cls_done, cls_ok, det_req, cls_req, port_on, port_clear, disc_set;
  logic osc_set, irq_n;
  logic disc_seen = 1'b0;
  int failures = 0;
  int num_checks = 0;
  pse_ctl_pkg::byte_t codes [8] = '{8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h20};
  pse_ctl_pkg::byte_t rst_exp [8] = '{8'hFF, 8'hF0, 8'hFF, 8'h00, 8'hA0, 8'h00, 8'h00, 8'h00};

  always #5 clk = ~clk;
  always @(posedge clk)
    if (disc_set[0] === 1'b1)
      disc_seen <= 1'b1;

  pse_port_mode_control #(.TICK_CYCLES(TICK), .MPDO_MS(20)) pse_port_mode_control_inst
  (
    .i_mclk(clk), .i_arst_n(arst_n), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
    .i_cmd_code(cmd_code), .i_cmd_data(cmd_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .i_auto_pin(auto_pin), .i_imp_high(imp_high), .i_cur_low(cur_low), .i_cur_over(cur_over),
    .i_foldback(foldback), .i_osc_invalid(osc_invalid), .i_detect_done(det_done),
    .i_classify_done(cls_done), .i_class_ok(cls_ok), .o_detect_req(det_req),
    .o_classify_req(cls_req), .o_port_on(port_on), .o_port_clear(port_clear),
    .o_disc_fault_set(disc_set), .o_osc_fail_set(osc_set), .i_irq_pending(irq_pending),
    .o_irq_n(irq_n)
  );

  pse_engine_model pse_engine_model_inst
  (
    .i_mclk(clk), .i_rst_n(arst_n), .i_detect_req(det_req), .i_classify_req(cls_req),
    .o_detect_done(det_done), .o_classify_done(cls_done), .o_class_ok(cls_ok)
  );

  task automatic check8(input string what, input pse_ctl_pkg::byte_t exp,
                        input pse_ctl_pkg::byte_t got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check4(input string what, input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input pse_ctl_pkg::byte_t code, input pse_ctl_pkg::byte_t data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= code;
    cmd_data <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input pse_ctl_pkg::byte_t code,
                        input pse_ctl_pkg::byte_t exp);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    cmd_code <= code;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    check4("read strobe", {3'h0, rd_valid}, 4'h1);
    check8(what, exp, rd_data);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #200_000;
    failures++;
    summarize();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    settle(10);
    for (int i = 0; i < 8; i++)
      rd_chk("reset value", codes[i], rst_exp[i]);
    settle(60);
    check4("auto power", port_on, 4'hF);
    $display("test reset values done");
    wr(8'h12, 8'h39);
    rd_chk("mode", 8'h12, 8'h39);
    wr(8'h19, 8'hF0);
    #1;
    check4("all off", port_on, 4'h0);
    check4("clear pulse", port_clear, 4'hF);
    rd_chk("enables cleared", 8'h14, 8'h00);
    wr(8'h18, 8'h66);
    settle(60);
    check4("semi waits auto powers", port_on, 4'h4);
    rd_chk("enables set", 8'h14, 8'h66);
    check4("classify request", cls_req, 4'h2);
    wr(8'h18, 8'h01);
    #1;
    check4("manual detect", {3'h0, det_req[0]}, 4'h1);
    settle(30);
    rd_chk("manual self clear", 8'h14, 8'h66);
    check4("manual stays off", port_on, 4'h4);
    wr(8'h19, 8'h08);
    settle(1);
    check4("off mode refuses", port_on, 4'h4);
    wr(8'h19, 8'h01);
    settle(1);
    check4("power on", port_on, 4'h5);
    wr(8'h19, 8'h11);
    #1;
    check4("on and off", port_on, 4'h4);
    check4("clear one", port_clear, 4'h1);
    $display("test modes and power done");
    wr(8'h17, 8'hFF);
    rd_chk("mask", 8'h17, 8'hA0);
    irq_pending <= 1'b1;
    settle(3);
    check4("irq active", {3'h0, irq_n}, 4'h0);
    wr(8'h17, 8'h20);
    settle(2);
    check4("irq gated", {3'h0, irq_n}, 4'h1);
    osc_invalid <= 1'b1;
    settle(5);
    check4("osc flag", {3'h0, osc_set}, 4'h1);
    wr(8'h17, 8'h80);
    settle(2);
    check4("osc gated", {3'h0, osc_set}, 4'h0);
    check4("irq again", {3'h0, irq_n}, 4'h0);
    irq_pending <= 1'b0;
    osc_invalid <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h16, {2'h3, c[1:0], c[1:0], c[1:0]});
      rd_chk("timing", 8'h16, {2'h0, c[1:0], c[1:0], c[1:0]});
    end
    $display("test mask and timing done");
    wr(8'h16, 8'h01);
    wr(8'h13, 8'h10);
    wr(8'h19, 8'h01);
    imp_high <= 4'h1;
    settle(50 * TICK);
    imp_high <= 4'h0;
    settle(2 * TICK);
    imp_high <= 4'h1;
    settle(85 * TICK);
    check4("disconnect wait", port_on, 4'h5);
    settle(10 * TICK);
    check4("disconnect off", port_on, 4'h4);
    check4("disconnect flag", {3'h0, disc_seen}, 4'h1);
    imp_high <= 4'h0;
    $display("test disconnect done");
    wr(8'h16, 8'h14);
    wr(8'h19, 8'h01);
    cur_over <= 4'h1;
    settle(55 * TICK);
    check4("inrush then count", port_on, 4'h5);
    settle(10 * TICK);
    check4("overcurrent off", port_on, 4'h4);
    cur_over <= 4'h0;
    wr(8'h19, 8'h01);
    settle(1);
    check4("refused while counting", port_on, 4'h4);
    settle(400 * TICK);
    wr(8'h19, 8'h01);
    settle(1);
    check4("slow drain", port_on, 4'h4);
    settle(100 * TICK);
    wr(8'h19, 8'h01);
    settle(1);
    check4("drained", port_on, 4'h5);
    $display("test overcurrent done");
    summarize();
  end
endmodule
`default_nettype wire

// ===== hdl/pse_port_mode_control.sv
// port mode, disconnect, detect/classify, timing, mask and power command registers
`timescale 1ns/100ps
`default_nettype none
`include "pse_ctl_defines.svh"
// Notes on behaviour
// (RULE_01) two-bit mode per port, port 4 on top
// (RULE_02) off mode unpowered; manual never acts alone
// (RULE_03) semi detects alone; auto also powers alone
// (RULE_04) modes, enables, ac bits load auto pin
// (RULE_05) high impedance runs timer; expiry powers off
// (RULE_06) low current runs timer; slow steady reset
// (RULE_07) classify enables high nibble, detect low
// (RULE_08) manual enable gives one cycle, self-clears
// (RULE_09) inrush time code in bits 5:4
// (RULE_10) overcurrent time code in bits 3:2
// (RULE_11) counter climbs after inrush; limit powers off
// (RULE_12) counter drains while off; blocks power-on
// (RULE_13) decrement at one sixteenth, floor zero
// (RULE_14) disconnect delay code in bits 1:0
// (RULE_15) one timing register for all ports, zero
// (RULE_16) gate bit blocks interrupt pin only
// (RULE_17) osc gate bit lets oscillator fault flag
// (RULE_18) restart ones trigger events; zeros ignored
// (RULE_19) restart register reads as zero
// (RULE_20) power command: off high, on low nibble
// (RULE_21) on bit powers port; both means off
// (RULE_22) command off clears port enables and flags
// (RULE_23) each register one byte by command code
module pse_port_mode_control
#(
  parameter int TICK_CYCLES = `MCLK_KHZ * `TICK_MS,
  parameter int MPDO_MS = `MPDO_MS
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // command port from the serial bus engine
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire pse_ctl_pkg::byte_t i_cmd_code,
  input wire pse_ctl_pkg::byte_t i_cmd_data,
  output pse_ctl_pkg::byte_t o_rd_data,
  output logic o_rd_valid,
  // pins and analog comparators
  input wire logic i_auto_pin,
  input wire logic [3:0] i_imp_high,
  input wire logic [3:0] i_cur_low,
  input wire logic [3:0] i_cur_over,
  input wire logic [3:0] i_foldback,
  input wire logic i_osc_invalid,
  // detect and classify engine
  input wire logic [3:0] i_detect_done,
  input wire logic [3:0] i_classify_done,
  input wire logic [3:0] i_class_ok,
  output logic [3:0] o_detect_req,
  output logic [3:0] o_classify_req,
  // port power and flags
  output logic [3:0] o_port_on,
  output logic [3:0] o_port_clear,
  output logic [3:0] o_disc_fault_set,
  output logic o_osc_fail_set,
  // interrupt pin
  input wire logic i_irq_pending,
  output logic o_irq_n
);
  localparam int REC_MS = (MPDO_MS * `RECOVER_PCT + 99) / 100;
  localparam pse_ctl_pkg::byte_t MASK_RESET = `MASK_RST;

  logic rst_s1;
  logic rst_n;
  logic [17:0] sync1;
  logic [17:0] sync2;
  logic auto_s;
  logic [3:0] imp_s;
  logic [3:0] low_s;
  logic [3:0] over_s;
  logic [3:0] fold_s;
  logic osc_s;
  logic [1:0] por_wait;
  logic por_load;
  logic [16:0] tick_cnt;
  logic tick;
  pse_ctl_pkg::byte_t port_operating_mode;
  pse_ctl_pkg::byte_t disconnect_enable;
  pse_ctl_pkg::byte_t detect_classify_enable;
  pse_ctl_pkg::byte_t fault_timing_config;
  logic irq_pin_gate;
  logic osc_fail_gate;
  logic [3:0] port_on;
  logic wr;
  logic rd;
  logic [3:0] off_mode;
  logic [3:0] man_mode;
  logic [3:0] auto_mode;
  logic [3:0] port_on_command;
  logic [3:0] port_off_command;
  logic [7:0] restart_bits;
  logic [3:0] disc_exp;
  logic [3:0] oc_exp;
  logic [3:0] oc_busy;
  logic [3:0] kill;
  logic [3:0] turn_on;
  logic [3:0] next_port_on;
  pse_ctl_pkg::byte_t next_dce;
  pse_ctl_pkg::ms_t inrush_ms;
  pse_ctl_pkg::ms_t oc_ms;
  pse_ctl_pkg::ms_t dis_ms;

  function automatic pse_ctl_pkg::ms_t fault_ms(input logic [1:0] code);
    case (code)
      2'h0: fault_ms = `T_60MS;
      2'h1: fault_ms = `T_30MS;
      2'h2: fault_ms = `T_120MS;
      default: fault_ms = `T_240MS;
    endcase
  endfunction

  function automatic pse_ctl_pkg::ms_t disc_ms(input logic [1:0] code);
    case (code)
      2'h0: disc_ms = `T_360MS;
      2'h1: disc_ms = `T_90MS;
      2'h2: disc_ms = `T_180MS;
      default: disc_ms = `T_720MS;
    endcase
  endfunction

  // reset release and pin synchronisers
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 18'h0_0000;
      sync2 <= 18'h0_0000;
    end
    else
    begin
      sync1 <= {i_auto_pin, i_osc_invalid, i_imp_high, i_cur_low, i_cur_over, i_foldback};
      sync2 <= sync1;
    end
  end

  assign {auto_s, osc_s, imp_s, low_s, over_s, fold_s} = sync2;

  // auto pin is caught once the synchroniser has settled
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      por_wait <= `POR_WAIT;
    else if (por_wait != 2'h0)
      por_wait <= por_wait - 2'h1;
  end

  assign por_load = por_wait == 2'h1;

  // millisecond time base
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= 17'h0_0000;
    else if (tick)
      tick_cnt <= 17'h0_0000;
    else
      tick_cnt <= tick_cnt + 17'h0_0001;
  end

  assign tick = tick_cnt == 17'(TICK_CYCLES - 1);

  // command decode
  assign wr = i_cmd_valid && i_cmd_write && por_wait == 2'h0; // RULE_23
  assign rd = i_cmd_valid && !i_cmd_write;
  assign port_on_command = (wr && i_cmd_code == `CMD_PWR) ? i_cmd_data[3:0] : 4'h0; // RULE_20
  assign port_off_command = (wr && i_cmd_code == `CMD_PWR) ? i_cmd_data[7:4] : 4'h0;
  assign restart_bits = (wr && i_cmd_code == `CMD_RSTRT) ? i_cmd_data : 8'h00; // RULE_18

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      off_mode[i] = port_operating_mode[2*i +: 2] == `MODE_OFF; // RULE_01
      man_mode[i] = port_operating_mode[2*i +: 2] == `MODE_MAN;
      auto_mode[i] = port_operating_mode[2*i +: 2] == `MODE_AUTO;
    end
  end

  always_comb
  begin
    inrush_ms = fault_ms(fault_timing_config[`INRUSH_LSB +: 2]); // RULE_09
    oc_ms = fault_ms(fault_timing_config[`OC_LSB +: 2]); // RULE_10
    dis_ms = disc_ms(fault_timing_config[`DIS_LSB +: 2]); // RULE_14
  end

  // one timing set shared by all ports
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : port_tmr
      pse_port_timers u_tmr
      (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_tick(tick),
        .i_powered(port_on[g]),
        .i_ac_en(disconnect_enable[4 + g]),
        .i_dc_en(disconnect_enable[g]),
        .i_imp_high(imp_s[g]),
        .i_cur_low(low_s[g]),
        .i_cur_over(over_s[g]),
        .i_foldback(fold_s[g]),
        .i_inrush_ms(inrush_ms), // RULE_15
        .i_oc_ms(oc_ms),
        .i_dis_ms(dis_ms),
        .i_rec_ms(10'(REC_MS)),
        .o_disc_expire(disc_exp[g]),
        .o_oc_expire(oc_exp[g]),
        .o_oc_busy(oc_busy[g])
      );
    end
  endgenerate

  // power control: off has priority over every way of turning on
  assign kill = port_off_command | off_mode | disc_exp | oc_exp; // RULE_21 RULE_02 RULE_11
  assign turn_on = (port_on_command | (auto_mode & i_class_ok)) // RULE_03
    & ~off_mode & ~oc_busy; // RULE_12
  assign next_port_on = (port_on | turn_on) & ~kill; // RULE_21

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      port_on <= 4'h0;
    else
      port_on <= next_port_on;
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_port_clear <= 4'h0;
      o_disc_fault_set <= 4'h0;
    end
    else
    begin
      o_port_clear <= port_off_command; // RULE_22
      o_disc_fault_set <= disc_exp; // RULE_05 RULE_06
    end
  end

  // mode and disconnect enables
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_operating_mode <= 8'h00;
      disconnect_enable <= 8'h00;
    end
    else if (por_load)
    begin
      port_operating_mode <= {8{auto_s}}; // RULE_04
      disconnect_enable <= {{4{auto_s}}, 4'h0}; // RULE_04
    end
    else if (wr && i_cmd_code == `CMD_MODE)
      port_operating_mode <= i_cmd_data;
    else if (wr && i_cmd_code == `CMD_DISC)
      disconnect_enable <= i_cmd_data;
  end

  // detect/classify enables: restart sets win over completion clears
  always_comb
  begin
    next_dce = (wr && i_cmd_code == `CMD_DCEN) ? i_cmd_data : detect_classify_enable; // RULE_07
    next_dce = next_dce & ~({i_classify_done, i_detect_done} & {man_mode, man_mode}); // RULE_08
    next_dce = next_dce & ~{port_off_command, port_off_command}; // RULE_22
    next_dce = next_dce | restart_bits; // RULE_18
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      detect_classify_enable <= 8'h00;
    else if (por_load)
      detect_classify_enable <= {8{auto_s}}; // RULE_04
    else
      detect_classify_enable <= next_dce;
  end

  // cycles only on unpowered ports outside off mode
  assign o_detect_req = detect_classify_enable[3:0] & ~off_mode & ~port_on; // RULE_02
  assign o_classify_req = detect_classify_enable[7:4] & ~off_mode & ~port_on;
  assign o_port_on = port_on;

  // timing and mask registers
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_timing_config <= `TIME_RST; // RULE_15
      irq_pin_gate <= MASK_RESET[`IRQ_GATE_BIT];
      osc_fail_gate <= MASK_RESET[`OSC_GATE_BIT];
    end
    else if (wr && i_cmd_code == `CMD_TIME)
      fault_timing_config <= {2'h0, i_cmd_data[5:0]};
    else if (wr && i_cmd_code == `CMD_MASK)
    begin
      irq_pin_gate <= i_cmd_data[`IRQ_GATE_BIT];
      osc_fail_gate <= i_cmd_data[`OSC_GATE_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_irq_n <= 1'b1;
      o_osc_fail_set <= 1'b0;
    end
    else
    begin
      o_irq_n <= !(i_irq_pending && irq_pin_gate); // RULE_16
      o_osc_fail_set <= osc_s && osc_fail_gate; // RULE_17
    end
  end

  // read back, one cycle after the request
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= rd;
      if (!rd)
        o_rd_data <= o_rd_data;
      else if (i_cmd_code == `CMD_MODE)
        o_rd_data <= port_operating_mode;
      else if (i_cmd_code == `CMD_DISC)
        o_rd_data <= disconnect_enable;
      else if (i_cmd_code == `CMD_DCEN)
        o_rd_data <= detect_classify_enable;
      else if (i_cmd_code == `CMD_TIME)
        o_rd_data <= fault_timing_config;
      else if (i_cmd_code == `CMD_MASK)
        o_rd_data <= {irq_pin_gate, 1'b0, osc_fail_gate, 5'h00};
      else
        o_rd_data <= `WO_READ; // RULE_19
    end
  end

  a_off_unpowered: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_02
    1 |=> (port_on & $past(off_mode)) == 4'h0)
    else $error("port powered in off mode");
  a_restart_read: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_19
    rd && i_cmd_code == `CMD_RSTRT |=> o_rd_valid && o_rd_data == 8'h00)
    else $error("restart register read not zero");
  a_both_off: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_21
    wr && i_cmd_code == `CMD_PWR && i_cmd_data[4] |=> !port_on[0] && o_port_clear[0])
    else $error("port not off after off command");
  a_por_load: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_04
    por_load |=> disconnect_enable[3:0] == 4'h0
      && port_operating_mode == {8{$past(auto_s)}}
      && fault_timing_config == 8'h00)
    else $error("power-on values wrong");
  a_irq_gate: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_16
    !irq_pin_gate [*2] |=> o_irq_n)
    else $error("interrupt pin active while gated");
  a_osc_gate: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_17
    osc_fail_gate && osc_s |=> o_osc_fail_set)
    else $error("oscillator fault not flagged");
  a_manual_done: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_08
    man_mode[0] && i_detect_done[0] && !wr |=> !detect_classify_enable[0])
    else $error("manual detect enable not cleared");
  a_on_refused: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_12
    oc_busy[0] && !port_on[0] |=> !port_on[0])
    else $error("port powered while overcurrent counter busy");
  a_restart_set: assert property (@(posedge i_mclk) disable iff (!rst_n) // RULE_18
    restart_bits != 8'h00 |=>
      (detect_classify_enable & $past(restart_bits)) == $past(restart_bits))
    else $error("restart did not set enable");
  c_auto_on: cover property (@(posedge i_mclk) disable iff (!rst_n)
    auto_mode[0] && i_class_ok[0] ##1 port_on[0]);
  c_disc_off: cover property (@(posedge i_mclk) disable iff (!rst_n)
    port_on[1] && disc_exp[1] ##1 !port_on[1]);
  c_oc_off: cover property (@(posedge i_mclk) disable iff (!rst_n)
    port_on[2] && oc_exp[2] ##1 !port_on[2]);
endmodule
`default_nettype wire

// ===== hdl/pse_port_timers.sv
// per-port inrush window, overcurrent up/down counter and disconnect timer
`timescale 1ns/100ps
`default_nettype none
`include "pse_ctl_defines.svh"
module pse_port_timers
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // millisecond tick and port state
  input wire logic i_tick,
  input wire logic i_powered,
  input wire logic i_ac_en,
  input wire logic i_dc_en,
  // synchronised sense levels
  input wire logic i_imp_high,
  input wire logic i_cur_low,
  input wire logic i_cur_over,
  input wire logic i_foldback,
  // selected times in ms
  input wire pse_ctl_pkg::ms_t i_inrush_ms,
  input wire pse_ctl_pkg::ms_t i_oc_ms,
  input wire pse_ctl_pkg::ms_t i_dis_ms,
  input wire pse_ctl_pkg::ms_t i_rec_ms,
  // results
  output logic o_disc_expire,
  output logic o_oc_expire,
  output logic o_oc_busy
);
  pse_ctl_pkg::ms_t inrush_cnt;
  pse_ctl_pkg::ms_t oc_cnt;
  pse_ctl_pkg::ms_t dis_cnt;
  pse_ctl_pkg::ms_t rec_cnt;
  logic [3:0] dec_div;
  logic inrush_done;
  logic oc_up;
  logic disc_cond;
  logic dis_clear;

  assign inrush_done = inrush_cnt >= i_inrush_ms;
  assign oc_up = i_powered && inrush_done && i_cur_over; // RULE_11
  assign disc_cond = (i_ac_en && i_imp_high) || (i_dc_en && i_cur_low);
  // ac clears on low impedance, dc only after a steady recovery
  assign dis_clear = (i_ac_en && !i_imp_high && !(i_dc_en && i_cur_low)) // RULE_05
    || (i_dc_en && rec_cnt >= i_rec_ms && !(i_ac_en && i_imp_high)); // RULE_06
  assign o_disc_expire = i_powered && (i_ac_en || i_dc_en) && dis_cnt >= i_dis_ms; // RULE_14
  assign o_oc_expire = i_powered && oc_cnt >= i_oc_ms; // RULE_11
  assign o_oc_busy = oc_cnt != 10'h000; // RULE_12

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      inrush_cnt <= 10'h000;
    else if (!i_powered)
      inrush_cnt <= 10'h000;
    else if (i_tick && !inrush_done)
      inrush_cnt <= inrush_cnt + 10'h001;
  end

  // counts down at a sixteenth of the up rate, also while off
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      oc_cnt <= 10'h000;
      dec_div <= 4'h0;
    end
    else if (i_tick)
    begin
      if (oc_up)
      begin
        dec_div <= 4'h0;
        if (oc_cnt < i_oc_ms)
          oc_cnt <= oc_cnt + 10'h001;
      end
      else if (!i_foldback && oc_cnt != 10'h000) // RULE_13
      begin
        dec_div <= dec_div + 4'h1;
        if (dec_div == `DEC_DIV_MAX)
          oc_cnt <= oc_cnt - 10'h001; // RULE_12
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dis_cnt <= 10'h000;
      rec_cnt <= 10'h000;
    end
    else
    begin
      if (!i_powered || i_cur_low)
        rec_cnt <= 10'h000;
      else if (i_tick && rec_cnt < i_rec_ms)
        rec_cnt <= rec_cnt + 10'h001;
      if (!i_powered || !(i_ac_en || i_dc_en) || dis_clear)
        dis_cnt <= 10'h000;
      else if (disc_cond && i_tick && dis_cnt < i_dis_ms)
        dis_cnt <= dis_cnt + 10'h001;
    end
  end

  a_oc_floor: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_13
    oc_cnt == 10'h000 && !oc_up |=> oc_cnt == 10'h000)
    else $error("overcurrent counter left zero without overcurrent");
  a_ac_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE_05
    i_powered && i_ac_en && !i_dc_en && !i_imp_high |=> dis_cnt == 10'h000)
    else $error("ac disconnect timer not cleared");
endmodule
`default_nettype wire

// ===== inc/pse_ctl_defines.svh
// register offsets, reset values and timing constants of the port mode control block
`ifndef PSE_CTL_DEFINES_SVH
`define PSE_CTL_DEFINES_SVH
`define CMD_MODE 8'h12
`define CMD_DISC 8'h13
`define CMD_DCEN 8'h14
`define CMD_TIME 8'h16
`define CMD_MASK 8'h17
`define CMD_RSTRT 8'h18
`define CMD_PWR 8'h19
`define MODE_OFF 2'h0
`define MODE_MAN 2'h1
`define MODE_SEMI 2'h2
`define MODE_AUTO 2'h3
`define TIME_RST 8'h00
`define MASK_RST 8'hA0
`define IRQ_GATE_BIT 7
`define OSC_GATE_BIT 5
`define INRUSH_LSB 4
`define OC_LSB 2
`define DIS_LSB 0
`define WO_READ 8'h00
`define POR_WAIT 2'h3
`define MCLK_KHZ 100000
`define TICK_MS 1
`define T_30MS 10'h01E
`define T_60MS 10'h03C
`define T_120MS 10'h078
`define T_240MS 10'h0F0
`define T_90MS 10'h05A
`define T_180MS 10'h0B4
`define T_360MS 10'h168
`define T_720MS 10'h2D0
`define MPDO_MS 400
`define RECOVER_PCT 17
`define DEC_DIV_MAX 4'hF
`endif

// ===== inc/pse_ctl_pkg.sv
// shared types of the port mode control block
package pse_ctl_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [9:0] ms_t;
endpackage
